// ===== rtl/peb_consts.vh
`ifndef PEB_CONSTS_VH
`define PEB_CONSTS_VH
// ==========================================================
// Register map
`define PEB_OFS_PORT0 8'h80
`define PEB_OFS_PORT1 8'h90
`define PEB_OFS_PORT2 8'ha0
`define PEB_OFS_PORT3 8'hb0
`define PEB_OFS_AUX 8'h8e
`define PEB_OFS_STATUS 8'h8f
`define PEB_PORT_RESET 8'hff
`define PEB_AUX_ALEDIS_BIT 0
// ==========================================================
// Machine cycle timing, in oscillator periods
`define PEB_CYCLE_LEN 4'd12
`define PEB_PH_LAST 4'd11
`define PEB_PH_HALF 4'd6
`define PEB_PH_STROBE 4'd3
`define PEB_PH_CODE_LO 4'd5
`define PEB_PH_DATA_SMP 4'd10
`define PEB_RST_MCYCLES 2
`define PEB_RST_CLKS (`PEB_RST_MCYCLES * 12)
// ==========================================================
// Access kinds
`define PEB_K_FETCH 2'd0
`define PEB_K_XREAD 2'd1
`define PEB_K_XWRITE 2'd2
`define PEB_K_TABLE 2'd3
`endif

// ===== rtl/peb_rst_filter.v
`timescale 1ns/10ps
`include "peb_consts.vh"
module peb_rst_filter #(
  parameter HOLD_CLKS = `PEB_RST_CLKS
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire rst_pin,
  output reg device_reset
);
  reg [5:0] cnt_reg;
  // Glitches shorter than two machine cycles never reach the core
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 6'h00;
      device_reset <= 1'b0;
    end else if (!rst_pin) begin
      cnt_reg <= 6'h00;
      device_reset <= 1'b0;
    end else if (cnt_reg < HOLD_CLKS[5:0] - 6'd1) begin
      cnt_reg <= cnt_reg + 6'd1;
    end else begin
      device_reset <= 1'b1;
    end
  end
endmodule

// ===== rtl/peb_qport.v
`timescale 1ns/10ps
`include "peb_consts.vh"
module peb_qport #(
  parameter W = 8
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire [W-1:0] latch,
  input wire [W-1:0] alt_out,
  input wire strong_en,
  input wire [W-1:0] strong_val,
  input wire release_all,
  output reg [W-1:0] pin_o,
  output reg [W-1:0] pin_oe
);
  // Pullup is outside: a one leaves the pin undriven and readable
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_o <= {W{1'b0}};
      pin_oe <= {W{1'b0}};
    end else if (release_all) begin
      pin_o <= {W{1'b0}};
      pin_oe <= {W{1'b0}};
    end else if (strong_en) begin
      pin_o <= strong_val;
      pin_oe <= {W{1'b1}};
    end else begin
      pin_o <= {W{1'b0}};
      pin_oe <= ~(latch & alt_out);
    end
  end
endmodule

// ===== rtl/peb_top.v
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`include "peb_consts.vh"
module peb_top #(
  parameter RST_HOLD = `PEB_RST_CLKS
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_we,
  input wire reg_re,
  output reg [7:0] reg_rdata,
  input wire cmd_valid,
  input wire [1:0] cmd_kind,
  input wire cmd_wide,
  input wire [15:0] cmd_addr,
  input wire [7:0] cmd_wdata,
  output wire cmd_ready,
  output reg rsp_valid,
  output reg [15:0] rsp_data,
  input wire [7:0] p0_i,
  output reg [7:0] p0_o,
  output reg [7:0] p0_oe,
  input wire [7:0] p1_i,
  output wire [7:0] p1_o,
  output wire [7:0] p1_oe,
  input wire [7:0] p2_i,
  output wire [7:0] p2_o,
  output wire [7:0] p2_oe,
  input wire [7:0] p3_i,
  output wire [7:0] p3_o,
  output wire [7:0] p3_oe,
  input wire ale_i,
  output reg ale_o,
  output reg ale_oe,
  output reg code_read_strobe_n,
  input wire external_fetch_select_n,
  input wire lock_bit_one,
  input wire rst_pin,
  output wire device_reset,
  input wire t2_clock_out,
  input wire serial_txd,
  output wire timer_two_count_input,
  output wire timer_two_trigger_input,
  output wire serial_rxd,
  output wire ext_irq_zero_n,
  output wire ext_irq_one_n,
  output wire timer_zero_input,
  output wire timer_one_input,
  input wire flash_flash_write_pulse_mode,
  input wire flash_verify_mode,
  input wire [7:0] flash_verify_byte,
  output reg [7:0] flash_code_byte,
  output reg [15:0] flash_addr,
  output reg flash_write_stb
);
  // ==========================================================
  // Port latches and ALE disable, plus strap capture and ALE input delay state
  reg [7:0] p0_latch_reg;
  reg [7:0] p1_latch_reg;
  reg [7:0] p2_latch_reg;
  reg [7:0] p3_latch_reg;
  reg aledis_reg;
  reg ea_held_reg;
  reg ea_armed_reg;
  reg ale_i_d_reg;

  // ==========================================================
  // Machine cycle sequencer
  reg [3:0] phase_reg;
  reg [3:0] phase_next;
  reg acc_active_reg;
  reg acc_active_next;
  reg [1:0] acc_kind_reg;
  reg [1:0] acc_kind_next;
  reg acc_wide_reg;
  reg acc_wide_next;
  reg [15:0] acc_addr_reg;
  reg [15:0] acc_addr_next;
  reg [7:0] acc_wdata_reg;
  reg [7:0] acc_wdata_next;
  reg [7:0] code_lo_reg;

  wire flash_mode = flash_flash_write_pulse_mode | flash_verify_mode;
  wire ea_level = lock_bit_one ? ea_held_reg : external_fetch_select_n;
  wire ext_exec = ~ea_level;

  assign cmd_ready = (phase_reg == `PEB_PH_LAST) & ~flash_mode;
  wire cmd_take = cmd_valid & cmd_ready;

  function is_data;
    input [1:0] kind;
    begin
      is_data = (kind == `PEB_K_XREAD) | (kind == `PEB_K_XWRITE);
    end
  endfunction

  function in_range;
    input [3:0] ph;
    input [3:0] lo;
    input [3:0] hi;
    begin
      in_range = (ph >= lo) & (ph <= hi);
    end
  endfunction

  always @* begin
    phase_next = (phase_reg == `PEB_PH_LAST) ? 4'd0 : phase_reg + 4'd1;
    acc_active_next = acc_active_reg;
    acc_kind_next = acc_kind_reg;
    acc_wide_next = acc_wide_reg;
    acc_addr_next = acc_addr_reg;
    acc_wdata_next = acc_wdata_reg;
    if (phase_reg == `PEB_PH_LAST) begin
      acc_active_next = cmd_take;
      if (cmd_take) begin
        acc_kind_next = cmd_kind;
        acc_wide_next = cmd_wide;
        acc_addr_next = cmd_addr;
        acc_wdata_next = cmd_wdata;
      end
    end
  end

  // ==========================================================
  // Bus pin plan for the coming phase
  reg ale_o_next;
  reg ale_oe_next;
  reg code_read_strobe_n_next;
  reg [7:0] p0_o_next;
  reg [7:0] p0_oe_next;
  reg p2_strong_next;
  reg [7:0] p2_val_next;
  reg rd_n_next;
  reg wr_n_next;
  reg [15:0] bus_addr;
  reg data_acc;
  reg bus_on;
  reg second_half;

  always @* begin
    data_acc = acc_active_next & is_data(acc_kind_next);
    bus_on = ~flash_mode & (ext_exec | acc_active_next);
    second_half = phase_next >= `PEB_PH_HALF;
    bus_addr = acc_addr_next;
    if (second_half & ~data_acc) begin
      bus_addr = acc_addr_next + 16'h0001;
    end
    // Two slots per machine cycle give one sixth of the oscillator rate
    ale_o_next = in_range(phase_next, 4'd0, 4'd1) | in_range(phase_next, 4'd6, 4'd7);
    if (data_acc & second_half) begin
      ale_o_next = 1'b0;
    end
    // Left undriven the pin sits on its weak pullup
    ale_oe_next = ~flash_mode & (~aledis_reg | ext_exec | acc_active_next);
    code_read_strobe_n_next = 1'b1;
    if (bus_on & ~data_acc & (ext_exec | acc_active_next)) begin
      code_read_strobe_n_next = ~(in_range(phase_next, 4'd3, 4'd5) | in_range(phase_next, 4'd9, 4'd11));
    end
    rd_n_next = 1'b1;
    wr_n_next = 1'b1;
    if (data_acc & in_range(phase_next, `PEB_PH_STROBE, `PEB_PH_DATA_SMP)) begin
      rd_n_next = acc_kind_next != `PEB_K_XREAD;
      wr_n_next = acc_kind_next != `PEB_K_XWRITE;
    end
    p0_o_next = 8'h00;
    p0_oe_next = ~p0_latch_reg;
    if (flash_flash_write_pulse_mode) begin
      p0_oe_next = 8'h00;
    end else if (flash_verify_mode) begin
      p0_oe_next = ~flash_verify_byte;
    end else if (bus_on) begin
      if (in_range(phase_next, 4'd0, 4'd2) | (~data_acc & in_range(phase_next, 4'd6, 4'd8))) begin
        p0_o_next = bus_addr[7:0];
        p0_oe_next = 8'hff;
      end else if (data_acc & (acc_kind_next == `PEB_K_XWRITE) & (phase_next >= `PEB_PH_STROBE)) begin
        p0_o_next = acc_wdata_next;
        p0_oe_next = 8'hff;
      end else begin
        p0_oe_next = 8'h00;
      end
    end
    p2_strong_next = bus_on & ~(data_acc & ~acc_wide_next);
    p2_val_next = bus_addr[15:8];
  end

  // ==========================================================
  // Sequencer and pin registers
  reg p2_strong_reg;
  reg [7:0] p2_val_reg;

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_reg <= 4'd0;
      acc_active_reg <= 1'b0;
      acc_kind_reg <= `PEB_K_FETCH;
      acc_wide_reg <= 1'b0;
      acc_addr_reg <= 16'h0000;
      acc_wdata_reg <= 8'h00;
      // Phase 0 plan, so the first pulse after reset is full width
      ale_o <= 1'b1;
      ale_oe <= 1'b0;
      code_read_strobe_n <= 1'b1;
      p0_o <= 8'h00;
      p0_oe <= 8'h00;
      p2_strong_reg <= 1'b0;
      p2_val_reg <= 8'h00;
    end else begin
      phase_reg <= phase_next;
      acc_active_reg <= acc_active_next;
      acc_kind_reg <= acc_kind_next;
      acc_wide_reg <= acc_wide_next;
      acc_addr_reg <= acc_addr_next;
      acc_wdata_reg <= acc_wdata_next;
      ale_o <= ale_o_next;
      ale_oe <= ale_oe_next;
      code_read_strobe_n <= code_read_strobe_n_next;
      p0_o <= p0_o_next;
      p0_oe <= p0_oe_next;
      p2_strong_reg <= p2_strong_next;
      p2_val_reg <= p2_val_next;
    end
  end

  // ==========================================================
  // Read data capture
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_lo_reg <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      if (acc_active_reg & ~is_data(acc_kind_reg) & (phase_reg == `PEB_PH_CODE_LO)) begin
        code_lo_reg <= p0_i;
      end
      if (acc_active_reg & (acc_kind_reg == `PEB_K_XREAD) & (phase_reg == `PEB_PH_DATA_SMP)) begin
        code_lo_reg <= p0_i;
      end
      if (acc_active_reg & (phase_reg == `PEB_PH_LAST)) begin
        rsp_valid <= 1'b1;
        if (is_data(acc_kind_reg)) begin
          rsp_data <= {8'h00, code_lo_reg};
        end else begin
          rsp_data <= {p0_i, code_lo_reg};
        end
      end
    end
  end

  // ==========================================================
  // Quasi-bidirectional ports
  wire [7:0] p1_alt = {7'h7f, t2_clock_out};
  // Strobes fed from the plan, so the port flop puts them in phase
  wire [7:0] p3_alt = {rd_n_next, wr_n_next, 4'hf, serial_txd, 1'b1};

  peb_qport #(.W(8)) u_port1 (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .latch(p1_latch_reg),
    .alt_out(p1_alt),
    .strong_en(1'b0),
    .strong_val(8'h00),
    .release_all(flash_mode),
    .pin_o(p1_o),
    .pin_oe(p1_oe)
  );

  peb_qport #(.W(8)) u_port2 (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .latch(p2_latch_reg),
    .alt_out(8'hff),
    .strong_en(p2_strong_reg),
    .strong_val(p2_val_reg),
    .release_all(flash_mode),
    .pin_o(p2_o),
    .pin_oe(p2_oe)
  );

  peb_qport #(.W(8)) u_port3 (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .latch(p3_latch_reg),
    .alt_out(p3_alt),
    .strong_en(1'b0),
    .strong_val(8'h00),
    .release_all(1'b0),
    .pin_o(p3_o),
    .pin_oe(p3_oe)
  );

  assign timer_two_count_input = p1_i[0];
  assign timer_two_trigger_input = p1_i[1];
  assign serial_rxd = p3_i[0];
  assign ext_irq_zero_n = p3_i[2];
  assign ext_irq_one_n = p3_i[3];
  assign timer_zero_input = p3_i[4];
  assign timer_one_input = p3_i[5];

  peb_rst_filter #(.HOLD_CLKS(RST_HOLD)) u_rst (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .rst_pin(rst_pin),
    .device_reset(device_reset)
  );

  // ==========================================================
  // Register port; pins are read, not latches, so inputs show
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      p0_latch_reg <= `PEB_PORT_RESET;
      p1_latch_reg <= `PEB_PORT_RESET;
      p2_latch_reg <= `PEB_PORT_RESET;
      p3_latch_reg <= `PEB_PORT_RESET;
      aledis_reg <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= 8'h00;
      if (reg_we) begin
        if (reg_addr == `PEB_OFS_PORT0) begin
          p0_latch_reg <= reg_wdata;
        end else if (reg_addr == `PEB_OFS_PORT1) begin
          p1_latch_reg <= reg_wdata;
        end else if (reg_addr == `PEB_OFS_PORT2) begin
          p2_latch_reg <= reg_wdata;
        end else if (reg_addr == `PEB_OFS_PORT3) begin
          p3_latch_reg <= reg_wdata;
        end else if (reg_addr == `PEB_OFS_AUX) begin
          aledis_reg <= reg_wdata[`PEB_AUX_ALEDIS_BIT];
        end
      end
      if (reg_re) begin
        if (reg_addr == `PEB_OFS_PORT0) begin
          reg_rdata <= p0_i;
        end else if (reg_addr == `PEB_OFS_PORT1) begin
          reg_rdata <= p1_i;
        end else if (reg_addr == `PEB_OFS_PORT2) begin
          reg_rdata <= p2_i;
        end else if (reg_addr == `PEB_OFS_PORT3) begin
          reg_rdata <= p3_i;
        end else if (reg_addr == `PEB_OFS_AUX) begin
          reg_rdata <= {7'h00, aledis_reg};
        end else if (reg_addr == `PEB_OFS_STATUS) begin
          reg_rdata <= {4'h0, flash_mode, acc_active_reg, ext_exec, ea_level};
        end
      end
    end
  end

  // ==========================================================
  // Strap capture and flash programming
  // Strap is taken on the first edge after release, not under reset
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ea_held_reg <= 1'b1;
      ea_armed_reg <= 1'b1;
    end else if (ea_armed_reg) begin
      ea_held_reg <= external_fetch_select_n;
      ea_armed_reg <= 1'b0;
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ale_i_d_reg <= 1'b1;
      flash_code_byte <= 8'h00;
      flash_addr <= 16'h0000;
      flash_write_stb <= 1'b0;
    end else begin
      ale_i_d_reg <= ale_i;
      flash_write_stb <= 1'b0;
      if (flash_mode) begin
        flash_addr <= {p2_i, p1_i};
      end
      if (flash_flash_write_pulse_mode & ale_i_d_reg & ~ale_i) begin
        flash_code_byte <= p0_i;
        flash_write_stb <= 1'b1;
      end
    end
  end
endmodule

// ===== verification/peb_checker.sv
`timescale 1ns/10ps
// ==========================================
// Bus timing, response time and reset pin filter checks
module peb_checker #(
  parameter RST_HOLD = 24
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire rsp_valid,
  input wire [7:0] p0_oe,
  input wire [7:0] p3_o,
  input wire [7:0] p3_oe,
  input wire ale_o,
  input wire code_read_strobe_n,
  input wire rst_pin,
  input wire device_reset
);
  wire rd_n = !(p3_oe[7] && !p3_o[7]);
  wire wr_n = !(p3_oe[6] && !p3_o[6]);
  reg [7:0] hold_reg;
  // Saturates so a long hold never wraps
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst || !rst_pin)
      hold_reg <= 8'h00;
    else if (hold_reg != 8'hff)
      hold_reg <= hold_reg + 8'h01;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_ale_width: assert property (
    $rose(ale_o) |=> ale_o ##1 (!ale_o)[*4]) else $error("ale pulse spacing wrong");
  a_code_read_strobe_width: assert property (
    $fell(code_read_strobe_n) |=> !code_read_strobe_n ##1 !code_read_strobe_n
    ##1 code_read_strobe_n) else $error("code strobe width wrong");
  a_code_read_strobe_order: assert property (
    $fell(code_read_strobe_n) |-> !ale_o && $past(ale_o, 2)) else $error("code strobe early");
  a_code_read_strobe_bus_free: assert property (
    !code_read_strobe_n |-> p0_oe == 8'h00) else $error("port zero driven in code read");
  a_rd_strobe: assert property (
    $fell(rd_n) |-> $past(ale_o, 2) ##1 (!rd_n)[*7] ##1 rd_n) else $error("read strobe wrong");
  a_xdata_no_ale: assert property (
    (!rd_n || !wr_n) |-> !ale_o) else $error("ale during data strobe");
  a_wr_drives_p0: assert property (
    !wr_n |-> p0_oe == 8'hff) else $error("port zero not driven in write");
  a_resp_time: assert property (
    cmd_valid && cmd_ready |-> ##[12:14] rsp_valid) else $error("no response in time");
  a_rst_filter: assert property (
    $rose(device_reset) |-> hold_reg >= RST_HOLD) else $error("reset pin filter too short");
  a_rst_release: assert property (
    !rst_pin |=> !device_reset) else $error("device reset held after pin low");
endmodule

bind peb_top peb_checker #(.RST_HOLD(RST_HOLD)) peb_checker_i (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
  .p0_oe(p0_oe), .p3_o(p3_o), .p3_oe(p3_oe), .ale_o(ale_o),
  .code_read_strobe_n(code_read_strobe_n), .rst_pin(rst_pin), .device_reset(device_reset));

// ===== verification/peb_mem_model.sv
`timescale 1ns/10ps
// ==========================================
// External memory: address latched at the ale fall
module peb_mem_model (
  input wire sys_clk,
  input wire ale_o,
  input wire code_read_strobe_n,
  input wire [7:0] p0_lvl,
  input wire [7:0] p2_lvl,
  input wire [7:0] p3_lvl,
  output wire mem_en,
  output wire [7:0] mem_val,
  output reg [15:0] wr_addr,
  output reg [7:0] wr_data
);
  reg [15:0] addr_reg = 16'h0000;
  reg ale_q = 1'b0;
  reg wr_q = 1'b1;
  assign mem_en = !code_read_strobe_n || !p3_lvl[7];
  assign mem_val = addr_reg[7:0] ^ addr_reg[15:8] ^ 8'h3c;
  always @(posedge sys_clk) begin
    ale_q <= ale_o;
    wr_q <= p3_lvl[6];
    if (ale_q && !ale_o)
      addr_reg <= {p2_lvl, p0_lvl};
    // Data taken at strobe end, the last moment it is sure to stand
    if (p3_lvl[6] && !wr_q)
      {wr_addr, wr_data} <= {addr_reg, p0_lvl};
  end
endmodule

// ===== verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic sys_clk = 1'b0, sys_rst = 1'b1, reg_we = 1'b0, reg_re = 1'b0, cmd_valid = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, cmd_wdata = 8'h00, rv;
  logic [1:0] cmd_kind = 2'd0;
  logic cmd_wide = 1'b0, ale_ext = 1'b1, rst_pin = 1'b0, lock_bit_one = 1'b0, tb_p0_en = 1'b0;
  logic external_fetch_select_n = 1'b1, t2_clock_out = 1'b1, serial_txd = 1'b1;
  logic flash_flash_write_pulse_mode = 1'b0, flash_verify_mode = 1'b0, ale_q = 1'b0, ps_q = 1'b1;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] p1_ext = 8'hff, p2_ext = 8'hff, p3_ext = 8'hff, tb_p0 = 8'hff, cyc = 8'h00;
  logic [7:0] flash_verify_byte = 8'h00;
  int miscompares = 0, n_tests = 0, ale_cnt = 0, ps_cnt = 0;
  wire [7:0] reg_rdata, p0_o, p0_oe, p1_o, p1_oe, p2_o, p2_oe, p3_o, p3_oe, mem_val, wr_data;
  wire [7:0] flash_code_byte;
  wire [15:0] rsp_data, flash_addr, wr_addr;
  wire cmd_ready, rsp_valid, ale_o, ale_oe, code_read_strobe_n, device_reset, mem_en;
  wire timer_two_count_input, timer_two_trigger_input, serial_rxd, ext_irq_zero_n;
  wire ext_irq_one_n, timer_zero_input, timer_one_input, flash_write_stb;
  // Floating port zero shows a changing pattern, never a stale value
  wire [7:0] p0_far = mem_en ? mem_val : (tb_p0_en ? tb_p0 : cyc ^ 8'ha5);
  wire [7:0] p0_i = (p0_oe & p0_o) | (~p0_oe & p0_far);
  wire [7:0] p1_i = (p1_oe & p1_o) | (~p1_oe & p1_ext);
  wire [7:0] p2_i = (p2_oe & p2_o) | (~p2_oe & p2_ext);
  wire [7:0] p3_i = (p3_oe & p3_o) | (~p3_oe & p3_ext);
  wire ale_i = ale_oe ? ale_o : ale_ext;
  peb_top #(.RST_HOLD(4)) peb_top_i (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_we,
    .reg_re, .reg_rdata, .cmd_valid, .cmd_kind, .cmd_wide, .cmd_addr, .cmd_wdata, .cmd_ready,
    .rsp_valid, .rsp_data, .p0_i, .p0_o, .p0_oe, .p1_i, .p1_o, .p1_oe, .p2_i, .p2_o, .p2_oe,
    .p3_i, .p3_o, .p3_oe, .ale_i, .ale_o, .ale_oe, .code_read_strobe_n,
    .external_fetch_select_n, .lock_bit_one, .rst_pin, .device_reset, .t2_clock_out,
    .serial_txd, .timer_two_count_input, .timer_two_trigger_input, .serial_rxd,
    .ext_irq_zero_n, .ext_irq_one_n, .timer_zero_input, .timer_one_input, .flash_flash_write_pulse_mode,
    .flash_verify_mode, .flash_verify_byte, .flash_code_byte, .flash_addr, .flash_write_stb);
  peb_mem_model peb_mem_model_i (.sys_clk, .ale_o, .code_read_strobe_n, .p0_lvl(p0_i),
    .p2_lvl(p2_i), .p3_lvl(p3_i), .mem_en, .mem_val, .wr_addr, .wr_data);
  // ==========================================
  // Clock, pin monitor, tasks
  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    ale_q <= ale_o & ale_oe;
    ps_q <= code_read_strobe_n;
    if ((ale_o & ale_oe) && !ale_q) ale_cnt++;
    if (!code_read_strobe_n && ps_q) ps_cnt++;
    cyc <= cyc + 8'h01;
  end
  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  task give_verdict;
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task win(input int n);
    ale_cnt = 0;
    ps_cnt = 0;
    tick(n);
  endtask
  task do_rst(input int n);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (n) @(posedge sys_clk);
    sys_rst <= 1'b0;
    tick(1);
  endtask
  task cmd(input logic [1:0] k, input logic w, input logic [15:0] a, input logic [7:0] d);
    int i;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_wide <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (cmd_ready !== 1'b1 && i < 30);
    cmd_valid <= 1'b0;
    #1 i = 0;
    ale_cnt = 0;
    ps_cnt = 0;
    while (rsp_valid !== 1'b1 && i < 30) begin
      tick(1);
      i++;
    end
    check(i < 30, 1);
  endtask
  // ==========================================
  // Scenarios
  initial begin
    do_rst(20);
    check(p0_oe, 8'h00);
    check(p1_oe | p2_oe | p3_oe, 8'h00);
    for (int j = 1; j < 4; j++) begin
      rd(8'h80 | 8'(j << 4));
      check(rv, 8'hff);
    end
    wr(8'h90, 8'h5a);
    rd(8'h90);
    check(rv, 8'h5a);
    check(p1_oe, 8'ha5);
    wr(8'h90, 8'hff);
    p1_ext <= 8'hf0;
    rd(8'h90);
    check(rv, 8'hf0);
    check({timer_two_trigger_input, timer_two_count_input}, 2'b00);
    p1_ext <= 8'hff;
    t2_clock_out <= 1'b0;
    p3_ext <= 8'b1110_1010;
    tick(2);
    check(p1_oe, 8'h01);
    check({timer_one_input, timer_zero_input, ext_irq_one_n, ext_irq_zero_n, serial_rxd},
          5'b10100);
    t2_clock_out <= 1'b1;
    serial_txd <= 1'b0;
    wr(8'hb0, 8'hc3);
    tick(1);
    check(p3_oe, 8'h3e);
    serial_txd <= 1'b1;
    wr(8'hb0, 8'hff);
    wr(8'h80, 8'h0f);
    tick(1);
    check(p0_oe, 8'hf0);
    wr(8'h80, 8'hff);
    win(24);
    check(ale_cnt, 4);
    check(ps_cnt, 0);
    cmd(2'd0, 1'b1, 16'h12fe, 8'h00);
    check(rsp_data, {mem(16'h12ff), mem(16'h12fe)});
    check(ale_cnt, 2);
    check(ps_cnt, 2);
    cmd(2'd1, 1'b1, 16'h3456, 8'h00);
    check(rsp_data, {8'h00, mem(16'h3456)});
    check(ale_cnt, 1);
    check(ps_cnt, 0);
    wr(8'ha0, 8'h77);
    cmd(2'd1, 1'b0, 16'h009a, 8'h00);
    check(rsp_data, {8'h00, mem(16'h779a)});
    wr(8'ha0, 8'hff);
    cmd(2'd2, 1'b1, 16'hbeef, 8'hc3);
    check(wr_addr, 16'hbeef);
    check(wr_data, 8'hc3);
    wr(8'h8e, 8'h01);
    rd(8'h8e);
    check(rv, 8'h01);
    rd(8'h81);
    check(rv, 8'h00);
    win(24);
    check(ale_cnt, 0);
    cmd(2'd3, 1'b1, 16'h0100, 8'h00);
    check(rsp_data[7:0], mem(16'h0100));
    check(ale_cnt, 2);
    external_fetch_select_n <= 1'b0;
    tick(4);
    win(24);
    check(ale_cnt, 4);
    check(ps_cnt, 4);
    external_fetch_select_n <= 1'b1;
    lock_bit_one <= 1'b1;
    do_rst(2);
    external_fetch_select_n <= 1'b0;
    tick(4);
    win(24);
    check(ps_cnt, 0);
    external_fetch_select_n <= 1'b1;
    lock_bit_one <= 1'b0;
    do_rst(2);
    rst_pin <= 1'b1;
    tick(3);
    check(device_reset, 1'b0);
    tick(3);
    check(device_reset, 1'b1);
    rst_pin <= 1'b0;
    tick(2);
    check(device_reset, 1'b0);
    flash_flash_write_pulse_mode <= 1'b1;
    tb_p0_en <= 1'b1;
    tb_p0 <= 8'ha7;
    p1_ext <= 8'h34;
    p2_ext <= 8'h12;
    tick(3);
    ale_ext <= 1'b0;
    for (int j = 0; j < 10 && flash_write_stb !== 1'b1; j++) tick(1);
    check(flash_write_stb, 1'b1);
    check(flash_code_byte, 8'ha7);
    check(flash_addr, 16'h1234);
    ale_ext <= 1'b1;
    flash_flash_write_pulse_mode <= 1'b0;
    flash_verify_mode <= 1'b1;
    flash_verify_byte <= 8'h3c;
    tb_p0 <= 8'hff;
    tick(3);
    check(p0_i, 8'h3c);
    give_verdict;
  end
  initial begin
    #250000;
    miscompares++;
    give_verdict;
  end
endmodule
